// ### inc/omc_pkg.sv
package omc_pkg;
  // ----------------------------------------------------------------
  // Register map: word index; byte address is index * 4.
  // ----------------------------------------------------------------
  localparam logic [11:0] OMC_IDX_REQUEST = 12'h8CF;
  localparam logic [11:0] OMC_IDX_RESULT = 12'h8D0;
  localparam logic [11:0] OMC_IDX_CTRL = 12'h8D1;
  localparam logic [11:0] OMC_IDX_STATUS = 12'h8D2;
  localparam logic [11:0] OMC_IDX_IRQ_STAT = 12'h8D3;
  localparam logic [11:0] OMC_IDX_IRQ_MASK = 12'h8D4;
  localparam logic [13:0] OMC_ADDR_REQUEST = {OMC_IDX_REQUEST, 2'b00};
  localparam logic [13:0] OMC_ADDR_RESULT = {OMC_IDX_RESULT, 2'b00};
  localparam logic [13:0] OMC_ADDR_CTRL = {OMC_IDX_CTRL, 2'b00};
  localparam logic [13:0] OMC_ADDR_STATUS = {OMC_IDX_STATUS, 2'b00};
  localparam logic [13:0] OMC_ADDR_IRQ_STAT = {OMC_IDX_IRQ_STAT, 2'b00};
  localparam logic [13:0] OMC_ADDR_IRQ_MASK = {OMC_IDX_IRQ_MASK, 2'b00};

  // ----------------------------------------------------------------
  // Mode codes and result codes
  // ----------------------------------------------------------------
  localparam logic [15:0] OMC_MODE_PARAM = 16'h0001;
  localparam logic [15:0] OMC_MODE_DIAG = 16'h0002;
  localparam logic [15:0] OMC_MODE_COMM = 16'h0003;
  localparam logic [15:0] OMC_MODE_FLASH_INIT = 16'h000F;
  localparam logic [15:0] OMC_RES_OK = 16'hA300;
  localparam logic [15:0] OMC_RES_BUSY = 16'hE302;
  localparam logic [15:0] OMC_RES_BACKUP = 16'hE303;
  localparam logic [15:0] OMC_RES_BAD_MODE = 16'hE301;
  localparam logic [15:0] OMC_RESET_WORD = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int OMC_CTRL_SAVE_VALID = 0;
  localparam int OMC_CTRL_SAVE_LO = 4;
  localparam int OMC_CTRL_SAVE_HI = 5;
  localparam int OMC_IRQ_DONE = 0;
  localparam int OMC_IRQ_FAIL = 1;
  localparam int OMC_IRQ_XSTOP = 2;
  localparam int OMC_IRQ_W = 3;
  localparam logic [2:0] OMC_IRQ_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Timing: least time to tear down cyclic exchange and apply a mode
  // ----------------------------------------------------------------
  localparam int OMC_CLK_MHZ = 125;
  localparam int OMC_SWITCH_NS = 64;
  localparam int OMC_SWITCH_CYC = (OMC_SWITCH_NS * OMC_CLK_MHZ + 999) / 1000;
  localparam logic [3:0] OMC_SWITCH_CNT = 4'(OMC_SWITCH_CYC);

  typedef enum logic [1:0] {
    OMC_PARAM, OMC_DIAG, OMC_COMM, OMC_FLASH
  } omc_mode_t;

  typedef enum logic [1:0] {
    OMC_IDLE, OMC_STOP, OMC_DONE
  } omc_state_t;
endpackage : omc_pkg

// ### rtl/omc_sync.sv
module omc_sync (
  // Clock, reset and enable.
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Asynchronous level and its synchronised copy.
  input wire logic async_in,
  output logic sync_out
);
  logic meta_reg;

  // Two flops; the first is read by the second and nothing else.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else if (clk_en) begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : omc_sync

// ### rtl/omc_top.sv
// Operation
// - Modes: param 1, diag 2, comm 3, flash
// - No saved mode: start in parameter mode
// - Download in param mode, then communication
// - Cyclic exchange only in communication mode
// - Flash mode restores default settings
// - On finish store result, raise done
// - Done falls after request falls
// - Failed change stores an error code
// - Stop exchange, drop running flag first
// - Busy acyclic services reject with E302H
// - Backup mode refuses, reports error code
module omc_top
  import omc_pkg::*;
(
  // Clock, reset and enable.
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Register port.
  input wire logic [13:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Handshake pins from the host.
  input wire logic mode_change_request_line,
  output logic mode_change_done_line,
  // Service status from the rest of the master.
  input wire logic acyclic_busy,
  input wire logic backup_mode,
  input wire logic download_active,
  // Mode and exchange outputs.
  output logic [1:0] mode_out,
  output logic exchange_running_flag,
  output logic flash_restore,
  output logic irq
);
  import omc_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic req_s;
  logic busy_s;
  logic backup_s;
  logic dl_s;

  omc_sync u_sync_req (.sys_clk(sys_clk), .resetn(resetn),
    .clk_en(clk_en), .async_in(mode_change_request_line),
    .sync_out(req_s));
  omc_sync u_sync_busy (.sys_clk(sys_clk), .resetn(resetn),
    .clk_en(clk_en), .async_in(acyclic_busy), .sync_out(busy_s));
  omc_sync u_sync_bkp (.sys_clk(sys_clk), .resetn(resetn),
    .clk_en(clk_en), .async_in(backup_mode), .sync_out(backup_s));
  omc_sync u_sync_dl (.sys_clk(sys_clk), .resetn(resetn),
    .clk_en(clk_en), .async_in(download_active), .sync_out(dl_s));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Maps a mode code to a mode; returns valid in bit 2.
  function automatic logic [2:0] decode_mode(input logic [15:0] code);
    case (code)
      OMC_MODE_PARAM: decode_mode = {1'b1, OMC_PARAM};
      OMC_MODE_DIAG: decode_mode = {1'b1, OMC_DIAG};
      OMC_MODE_COMM: decode_mode = {1'b1, OMC_COMM};
      OMC_MODE_FLASH_INIT: decode_mode = {1'b1, OMC_FLASH};
      default: decode_mode = 3'h0;
    endcase
  endfunction : decode_mode

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] request_word_reg;
  logic [15:0] result_word_reg;
  logic [15:0] latched_req_reg;
  logic [15:0] ctrl_reg;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_mask_reg;
  logic req_d_reg;
  logic dl_d_reg;
  logic started_reg;
  logic [3:0] cnt_reg;
  omc_state_t state_reg;
  omc_mode_t mode_reg;
  logic [2:0] ev_set;
  logic req_rise;
  logic req_fall;
  logic wr_req;
  logic [2:0] dec;

  assign req_rise = req_s && !req_d_reg;
  assign req_fall = !req_s && req_d_reg;
  assign wr_req = reg_wr && (reg_addr == OMC_ADDR_REQUEST);
  assign dec = decode_mode(latched_req_reg);

  // Edge history of the synchronised request and download levels.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      req_d_reg <= 1'b0;
      dl_d_reg <= 1'b0;
    end else if (clk_en) begin
      req_d_reg <= req_s;
      dl_d_reg <= dl_s;
    end
  end

  // Request word is free to software; the engine works from a copy.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      request_word_reg <= OMC_RESET_WORD;
    end else if (clk_en && wr_req) begin
      request_word_reg <= reg_wdata;
    end
  end

  // Copy taken only on the request rise, so later writes cannot
  // change a handshake already in flight.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      latched_req_reg <= OMC_RESET_WORD;
    end else if (clk_en && req_rise && state_reg == OMC_IDLE) begin
      latched_req_reg <= request_word_reg;
    end
  end

  // Control word: saved mode valid flag and saved mode code.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ctrl_reg <= OMC_RESET_WORD;
    end else if (clk_en && reg_wr && reg_addr == OMC_ADDR_CTRL) begin
      ctrl_reg <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Handshake engine
  // ----------------------------------------------------------------
  // Refusals are decided at the request rise; an accepted change
  // first tears down exchange for a fixed settle time.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_reg <= OMC_IDLE;
      cnt_reg <= 4'h0;
      result_word_reg <= OMC_RESET_WORD;
      mode_change_done_line <= 1'b0;
    end else if (clk_en) begin
      unique case (state_reg)
        OMC_IDLE: begin
          if (req_rise) begin
            if (busy_s) begin
              result_word_reg <= OMC_RES_BUSY;
              mode_change_done_line <= 1'b1;
              state_reg <= OMC_DONE;
            end else if (backup_s) begin
              result_word_reg <= OMC_RES_BACKUP;
              mode_change_done_line <= 1'b1;
              state_reg <= OMC_DONE;
            end else begin
              cnt_reg <= OMC_SWITCH_CNT;
              state_reg <= OMC_STOP;
            end
          end
        end
        OMC_STOP: begin
          if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
          end else begin
            result_word_reg <= dec[2] ? OMC_RES_OK
                                      : OMC_RES_BAD_MODE;
            mode_change_done_line <= 1'b1;
            state_reg <= OMC_DONE;
          end
        end
        OMC_DONE: begin
          if (req_fall || !req_s) begin
            mode_change_done_line <= 1'b0;
            state_reg <= OMC_IDLE;
          end
        end
        default: state_reg <= OMC_IDLE;
      endcase
    end
  end

  // Operating mode. Power-up check reads the saved value one cycle after reset
  // release, while ctrl_reg still holds its reset value, so it never applies.
  logic boot_reg;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      mode_reg <= OMC_PARAM;
      boot_reg <= 1'b1;
    end else if (clk_en) begin
      boot_reg <= 1'b0;
      if (boot_reg && ctrl_reg[OMC_CTRL_SAVE_VALID]) begin
        mode_reg <= omc_mode_t'(
          ctrl_reg[OMC_CTRL_SAVE_HI:OMC_CTRL_SAVE_LO]);
      end else if (dl_s) begin
        mode_reg <= OMC_PARAM;
      end else if (dl_d_reg) begin
        mode_reg <= OMC_COMM;
      end else if (state_reg == OMC_STOP && cnt_reg == 4'h0 && dec[2]) begin
        mode_reg <= omc_mode_t'(dec[1:0]);
      end
    end
  end

  // Exchange runs only in communication mode and never while a
  // change is in progress.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      started_reg <= 1'b0;
      exchange_running_flag <= 1'b0;
    end else if (clk_en) begin
      // Remembers whether exchange was live when a change was taken.
      if (state_reg == OMC_IDLE) begin
        started_reg <= exchange_running_flag;
      end
      exchange_running_flag <= (mode_reg == OMC_COMM)
                               && (state_reg == OMC_IDLE)
                               && !req_rise;
    end
  end

  // Flash restore strobe high while in flash initialisation mode.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      flash_restore <= 1'b0;
      mode_out <= 2'h0;
    end else if (clk_en) begin
      flash_restore <= (mode_reg == OMC_FLASH);
      mode_out <= mode_reg;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  always_comb begin
    ev_set = 3'h0;
    ev_set[OMC_IRQ_DONE] = (state_reg == OMC_STOP) && (cnt_reg == 4'h0);
    ev_set[OMC_IRQ_FAIL] = (state_reg == OMC_IDLE) && req_rise
                           && (busy_s || backup_s);
    ev_set[OMC_IRQ_XSTOP] = started_reg && (state_reg == OMC_STOP);
  end

  // Sticky status, write one to clear; a new event beats the clear.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      irq_stat_reg <= OMC_IRQ_RESET;
      irq_mask_reg <= OMC_IRQ_RESET;
      irq <= 1'b0;
    end else if (clk_en) begin
      if (reg_wr && reg_addr == OMC_ADDR_IRQ_STAT) begin
        irq_stat_reg <= (irq_stat_reg & ~reg_wdata[2:0]) | ev_set;
      end else begin
        irq_stat_reg <= irq_stat_reg | ev_set;
      end
      if (reg_wr && reg_addr == OMC_ADDR_IRQ_MASK) begin
        irq_mask_reg <= reg_wdata[2:0];
      end
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // Read port: data one cycle after the strobe, zero if unmapped.
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      reg_rdata <= 16'h0000;
      if (reg_rd) begin
        unique case (reg_addr)
          OMC_ADDR_REQUEST: reg_rdata <= request_word_reg;
          OMC_ADDR_RESULT: reg_rdata <= result_word_reg;
          OMC_ADDR_CTRL: reg_rdata <= ctrl_reg;
          OMC_ADDR_STATUS: reg_rdata <= {10'h000, state_reg,
                                         exchange_running_flag,
                                         mode_change_done_line, mode_reg};
          OMC_ADDR_IRQ_STAT: reg_rdata <= {13'h0000, irq_stat_reg};
          OMC_ADDR_IRQ_MASK: reg_rdata <= {13'h0000, irq_mask_reg};
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_busy_rise;
    clk_en && state_reg == OMC_IDLE && req_rise && busy_s;
  endsequence

  property p_busy_reject;
    @(posedge sys_clk) disable iff (!resetn)
      s_busy_rise |=> mode_change_done_line
                      && result_word_reg == OMC_RES_BUSY;
  endproperty
  a_busy_reject: assert property (p_busy_reject)
    else $error("busy request not rejected with E302");

  property p_backup_reject;
    @(posedge sys_clk) disable iff (!resetn)
      (clk_en && state_reg == OMC_IDLE && req_rise && !busy_s && backup_s)
      |=> result_word_reg == OMC_RES_BACKUP;
  endproperty
  a_backup_reject: assert property (p_backup_reject)
    else $error("backup mode request not refused");

  property p_done_falls;
    @(posedge sys_clk) disable iff (!resetn)
      (clk_en && state_reg == OMC_DONE && !req_s) |=> !mode_change_done_line;
  endproperty
  a_done_falls: assert property (p_done_falls)
    else $error("done line did not fall after request fell");

  property p_done_result;
    @(posedge sys_clk) disable iff (!resetn)
      $rose(mode_change_done_line) |-> result_word_reg != OMC_RESET_WORD;
  endproperty
  a_done_result: assert property (p_done_result)
    else $error("done raised without a result code");

  property p_exch_comm;
    @(posedge sys_clk) disable iff (!resetn)
      exchange_running_flag |-> $past(mode_reg) == OMC_COMM;
  endproperty
  a_exch_comm: assert property (p_exch_comm)
    else $error("exchange running outside communication mode");

  property p_exch_stop;
    @(posedge sys_clk) disable iff (!resetn)
      (state_reg == OMC_STOP) |-> ##1 !exchange_running_flag;
  endproperty
  a_exch_stop: assert property (p_exch_stop)
    else $error("exchange not stopped during mode change");

  property p_bad_code;
    @(posedge sys_clk) disable iff (!resetn)
      (clk_en && state_reg == OMC_STOP && cnt_reg == 4'h0 && !dec[2])
      |=> result_word_reg == OMC_RES_BAD_MODE;
  endproperty
  a_bad_code: assert property (p_bad_code)
    else $error("failed change did not store an error code");

  property p_latch_hold;
    @(posedge sys_clk) disable iff (!resetn)
      (state_reg != OMC_IDLE) |=> $stable(latched_req_reg);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("sampled request changed during handshake");
endmodule : omc_top

// ### dv/omc_host_model.sv
module omc_host_model (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Bench side: high while the bench wants a change in progress.
  input wire logic want,
  // Handshake pins.
  input wire logic mode_change_done_line,
  output logic mode_change_request_line
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Four-phase request driver
  // ----------------------------------------------------------------
  // A new request is raised only once the previous done has fallen, so
  // a stale done can never be taken as the answer to a fresh request.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      mode_change_request_line <= 1'b0;
    end else if (!want) begin
      mode_change_request_line <= 1'b0;
    end else if (!mode_change_done_line) begin
      mode_change_request_line <= 1'b1;
    end
  end
endmodule : omc_host_model

// ### dv/omc_top_tb.sv
module omc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import omc_pkg::*;

  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [13:0] reg_addr = 14'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic acyclic_busy = 1'b0;
  logic backup_mode = 1'b0;
  logic download_active = 1'b0;
  logic want = 1'b0;
  logic [15:0] reg_rdata;
  logic req;
  logic done;
  logic [1:0] mode_out;
  logic exch;
  logic flash_restore;
  logic irq;
  logic [15:0] rdv;
  int errors = 0;
  int check_count = 0;
  logic [15:0] codes [4] = '{OMC_MODE_COMM, OMC_MODE_DIAG,
                             OMC_MODE_FLASH_INIT, OMC_MODE_PARAM};
  omc_mode_t exp_m [4] = '{OMC_COMM, OMC_DIAG, OMC_FLASH, OMC_PARAM};

  // The bench clock runs at 125 MHz.
  always #4 sys_clk = ~sys_clk;

  omc_top u_dut (
    .sys_clk(sys_clk), .resetn(resetn), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mode_change_request_line(req), .mode_change_done_line(done),
    .acyclic_busy(acyclic_busy), .backup_mode(backup_mode),
    .download_active(download_active), .mode_out(mode_out),
    .exchange_running_flag(exch), .flash_restore(flash_restore),
    .irq(irq)
  );

  omc_host_model u_host (
    .sys_clk(sys_clk), .resetn(resetn), .want(want),
    .mode_change_done_line(done), .mode_change_request_line(req)
  );

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h", $time, what, got);
    end
  endtask : cmp

  task automatic cmp_bit(input logic got, input logic exp,
                         input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %b", $time, what, got);
    end
  endtask : cmp_bit

  // ----------------------------------------------------------------
  // Register port and handshake tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [13:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [13:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  // Full four-phase change; poke rewrites the word after capture.
  task automatic change(input logic [15:0] code, input logic [15:0] poke,
                        input bit do_poke, output logic [15:0] res);
    int n;
    wr(OMC_ADDR_REQUEST, code);
    @(posedge sys_clk);
    want <= 1'b1;
    if (do_poke) begin
      repeat (6) @(posedge sys_clk);
      wr(OMC_ADDR_REQUEST, poke);
    end
    n = 0;
    while (done !== 1'b1 && n < 60) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    cmp_bit(done, 1'b1, "done rise");
    if (code != OMC_MODE_COMM) begin
      cmp_bit(exch, 1'b0, "exchange outside comm");
    end
    rd(OMC_ADDR_RESULT, res);
    repeat (3) @(posedge sys_clk);
    #1;
    cmp_bit(done, 1'b1, "done held");
    @(posedge sys_clk);
    want <= 1'b0;
    n = 0;
    while (done !== 1'b0 && n < 12) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    cmp_bit(done, 1'b0, "done fall");
    repeat (2) @(posedge sys_clk);
  endtask : change

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    cmp({14'h0000, mode_out}, {14'h0000, OMC_PARAM}, "reset mode");
    cmp_bit(done, 1'b0, "reset done");
    cmp_bit(exch, 1'b0, "reset exchange");
    cmp_bit(irq, 1'b0, "reset irq");
    rd(OMC_ADDR_RESULT, rdv);
    cmp(rdv, OMC_RESET_WORD, "reset result");
    wr(OMC_ADDR_RESULT, 16'h1234);
    wr(14'h0000, 16'hFFFF);
    rd(OMC_ADDR_RESULT, rdv);
    cmp(rdv, OMC_RESET_WORD, "result read-only");
    rd(14'h0000, rdv);
    cmp(rdv, 16'h0000, "unmapped read");
    $display("test reset finished");

    // Every mode code in turn, leaving comm for diag on the way.
    for (int i = 0; i < 4; i++) begin
      change(codes[i], 16'h0000, 1'b0, rdv);
      cmp(rdv, OMC_RES_OK, "result ok");
      cmp({14'h0000, mode_out}, {14'h0000, exp_m[i]}, "mode");
      cmp_bit(flash_restore, exp_m[i] == OMC_FLASH, "flash");
      cmp_bit(exch, exp_m[i] == OMC_COMM, "exchange");
    end
    $display("test mode table finished");

    // Events stay hidden until unmasked and vanish on a one written.
    rd(OMC_ADDR_IRQ_STAT, rdv);
    cmp_bit(rdv[OMC_IRQ_DONE], 1'b1, "done event");
    cmp_bit(rdv[OMC_IRQ_XSTOP], 1'b1, "exchange stop event");
    cmp_bit(rdv[OMC_IRQ_FAIL], 1'b0, "no refusal event");
    cmp_bit(irq, 1'b0, "masked irq");
    wr(OMC_ADDR_IRQ_MASK, 16'h0003);
    repeat (2) @(posedge sys_clk);
    #1;
    cmp_bit(irq, 1'b1, "unmasked irq");
    wr(OMC_ADDR_IRQ_STAT, 16'h0007);
    repeat (2) @(posedge sys_clk);
    #1;
    cmp_bit(irq, 1'b0, "cleared irq");
    rd(OMC_ADDR_IRQ_STAT, rdv);
    cmp(rdv, 16'h0000, "status cleared");
    $display("test interrupts finished");

    // Refusals leave the mode alone and report their own codes.
    acyclic_busy <= 1'b1;
    change(OMC_MODE_DIAG, 16'h0000, 1'b0, rdv);
    cmp(rdv, OMC_RES_BUSY, "busy refusal");
    rd(OMC_ADDR_STATUS, rdv);
    cmp(rdv, {14'h0000, OMC_PARAM}, "mode before backup");
    @(posedge sys_clk);
    acyclic_busy <= 1'b0;
    backup_mode <= 1'b1;
    change(OMC_MODE_DIAG, 16'h0000, 1'b0, rdv);
    cmp(rdv, OMC_RES_BACKUP, "backup refusal");
    backup_mode <= 1'b0;
    change(16'h0007, 16'h0000, 1'b0, rdv);
    cmp(rdv, OMC_RES_BAD_MODE, "bad code");
    cmp({14'h0000, mode_out}, {14'h0000, OMC_PARAM}, "mode kept");
    rd(OMC_ADDR_IRQ_STAT, rdv);
    cmp_bit(rdv[OMC_IRQ_FAIL], 1'b1, "refused event");
    cmp_bit(irq, 1'b1, "refused irq");
    $display("test refusals finished");

    // A rewrite after capture must not change the applied mode.
    change(OMC_MODE_DIAG, OMC_MODE_COMM, 1'b1, rdv);
    cmp(rdv, OMC_RES_OK, "frozen ok");
    cmp({14'h0000, mode_out}, {14'h0000, OMC_DIAG}, "frozen");
    $display("test frozen word finished");

    // Download holds parameter mode, then moves to communication.
    download_active <= 1'b1;
    repeat (8) @(posedge sys_clk);
    #1;
    cmp({14'h0000, mode_out}, {14'h0000, OMC_PARAM}, "download");
    @(posedge sys_clk);
    download_active <= 1'b0;
    repeat (8) @(posedge sys_clk);
    #1;
    cmp({14'h0000, mode_out}, {14'h0000, OMC_COMM}, "after dl");
    cmp_bit(exch, 1'b1, "exchange after dl");
    $display("test download finished");
    close_out();
  end

  // A hang is cut short well after the tests should have ended.
  initial begin
    #100us;
    errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    close_out();
  end
endmodule : omc_top_tb
